/* spp_sector_protect.sv */
// sector password protection core with serial-clock command port
//
// Operation
// - password mode bit defaults off; clearing locks password
// - sector mode bit cleared forbids password mode
// - mode bits one-time, only one may clear
// - password set before mode; then never changed
// - in password mode, freeze returns to 1 only with password
// - wrong password keeps freeze and locks
// - shipped state leaves every sector unlocked
// - freeze bits 7:1 zero, bit0 gates locks
// - read-freeze command returns freeze bit
// - password mode: freeze locked after reset
// - correct unlock sets freeze bit to 1
// - write-freeze command clears freeze bit
// - nonvolatile lock 0 blocks sector, persists
// - volatile lock 1 blocks sector
// - nonvolatile write clears sector bit, program time
// - nonvolatile erase sets all bits, erase time
// - volatile write sets sector lock bit
// - reset clears every volatile lock bit
// - dedicated reads return each lock kind
// - lock-down bars volatile writes until reset
`timescale 1ns/1ps
`default_nettype none

module spp_sector_protect
	import spp_pkg::*;
#(
	parameter int SECTORS = SPP_SECTORS,
	parameter int SECT_W = SPP_SECT_W,
	parameter int PROG_CYCLES = SPP_PROG_CYCLES,
	parameter int ERASE_CYCLES = SPP_ERASE_CYCLES
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic volatile_reset,
	input wire logic sclk,
	input wire logic cmd_valid,
	input wire spp_cmd_e cmd_code,
	input wire logic [SECT_W-1:0] cmd_sector,
	input wire logic [SPP_DATA_W-1:0] cmd_data,
	output logic cmd_ready,
	output logic rsp_valid,
	output logic rsp_ok,
	output logic [SPP_DATA_W-1:0] rsp_data
);

	// nonvolatile operations occupy the sequencer for a cell time
	function automatic logic spp_is_nv_op(input spp_cmd_e c);
		spp_is_nv_op = (c == SPP_CMD_WR_MODE) || (c == SPP_CMD_WR_PW) ||
			(c == SPP_CMD_WR_NVL) || (c == SPP_CMD_ERASE_NVL);
	endfunction : spp_is_nv_op

	// link side holding registers, stable from capture until the answer
	spp_cmd_e l_cmd_reg;
	logic [SECT_W-1:0] l_sect_reg;
	logic [SPP_DATA_W-1:0] l_data_reg;
	logic req_tgl_reg;
	logic ack_s1_reg;
	logic ack_s2_reg;
	logic ack_s3_reg;
	logic ack_evt;

	// core side state
	logic req_s1_reg;
	logic req_s2_reg;
	logic req_s3_reg;
	logic req_evt;
	logic ack_tgl_reg;
	spp_state_e state_reg;
	logic [31:0] cnt_reg;
	logic c_ok_reg;
	logic [SPP_DATA_W-1:0] c_data_reg;
	logic [SPP_MODE_W-1:0] mode_reg;
	logic [SPP_PW_W-1:0] pw_reg;
	logic freeze_reg;
	logic [SECTORS-1:0] nvl_reg;
	logic [SECTORS-1:0] vol_wl_reg;
	logic [SECTORS-1:0] vol_ld_reg;

	// decode of the held command
	logic exec;
	logic done;
	logic pw_on;
	logic pw_match;
	logic access_ok;
	logic [SPP_MODE_W-1:0] mode_next;
	logic mode_ok;
	logic nv_ok;
	logic imm_ok;
	logic [SPP_DATA_W-1:0] imm_data;

	// link domain: capture a command, toggle the request, wait for the answer
	always_ff @(posedge sclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			l_cmd_reg <= SPP_CMD_RD_MODE;
			l_sect_reg <= '0;
			l_data_reg <= '0;
			req_tgl_reg <= 1'b0;
			cmd_ready <= 1'b1;
		end
		else if (cmd_valid && cmd_ready)
		begin
			l_cmd_reg <= cmd_code;
			l_sect_reg <= cmd_sector;
			l_data_reg <= cmd_data;
			req_tgl_reg <= ~req_tgl_reg;
			cmd_ready <= 1'b0;
		end
		else if (ack_evt)
		begin
			cmd_ready <= 1'b1;
		end
	end

	// answer toggle into the link domain; the first flop feeds no logic, the event comes from the second and third
	always_ff @(posedge sclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ack_s1_reg <= 1'b0;
			ack_s2_reg <= 1'b0;
			ack_s3_reg <= 1'b0;
		end
		else
		begin
			ack_s1_reg <= ack_tgl_reg;
			ack_s2_reg <= ack_s1_reg;
			ack_s3_reg <= ack_s2_reg;
		end
	end

	assign ack_evt = ack_s2_reg ^ ack_s3_reg;

	// answer words are held by the core until the next request, so a plain sample is safe
	always_ff @(posedge sclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rsp_valid <= 1'b0;
			rsp_ok <= 1'b0;
			rsp_data <= '0;
		end
		else
		begin
			rsp_valid <= ack_evt;
			if (ack_evt)
			begin
				rsp_ok <= c_ok_reg;
				rsp_data <= c_data_reg;
			end
		end
	end

	// request toggle into the core domain
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			req_s1_reg <= 1'b0;
			req_s2_reg <= 1'b0;
			req_s3_reg <= 1'b0;
		end
		else
		begin
			req_s1_reg <= req_tgl_reg;
			req_s2_reg <= req_s1_reg;
			req_s3_reg <= req_s2_reg;
		end
	end

	assign req_evt = req_s2_reg ^ req_s3_reg;
	assign exec = (state_reg == SPP_IDLE) && req_evt;
	assign done = (state_reg == SPP_BUSY) && (cnt_reg == 32'h0000_0000);

	// protection decode shared by sequencer and storage
	always_comb
	begin
		pw_on = ~mode_reg[SPP_MODE_PW_BIT];
		pw_match = (l_data_reg == pw_reg);
		access_ok = nvl_reg[l_sect_reg] & ~vol_wl_reg[l_sect_reg];
		// one-time bits only fall; reserved bits stay 1
		mode_next = mode_reg & (l_data_reg[SPP_MODE_W-1:0] | SPP_MODE_RESET &
			~((16'h0001 << SPP_MODE_PW_BIT) | (16'h0001 << SPP_MODE_SP_BIT)));
		mode_ok = mode_next[SPP_MODE_PW_BIT] | mode_next[SPP_MODE_SP_BIT];
		nv_ok = 1'b0;
		unique case (l_cmd_reg)
			SPP_CMD_WR_MODE: nv_ok = mode_ok;
			SPP_CMD_WR_PW: nv_ok = ~pw_on;
			SPP_CMD_WR_NVL: nv_ok = freeze_reg;
			SPP_CMD_ERASE_NVL: nv_ok = freeze_reg;
			default: nv_ok = 1'b0;
		endcase
	end

	// answers of the commands that complete at once
	always_comb
	begin
		imm_ok = 1'b1;
		imm_data = '0;
		unique case (l_cmd_reg)
			SPP_CMD_RD_MODE: imm_data[SPP_MODE_W-1:0] = mode_reg;
			SPP_CMD_RD_FREEZE: imm_data[SPP_FREEZE_W-1:0] = {SPP_FREEZE_RSVD, freeze_reg};
			SPP_CMD_WR_FREEZE: imm_ok = 1'b1;
			SPP_CMD_UNLOCK_PW: imm_ok = ~pw_on | pw_match;
			SPP_CMD_RD_PW:
			begin
				// once password mode is set the password never leaves the block
				imm_ok = ~pw_on;
				imm_data = pw_on ? '0 : pw_reg;
			end
			SPP_CMD_RD_NVL: imm_data[0] = nvl_reg[l_sect_reg];
			SPP_CMD_WR_VOL: imm_ok = ~vol_ld_reg[l_sect_reg];
			SPP_CMD_RD_VOL:
			begin
				imm_data[SPP_VOL_WL_BIT] = vol_wl_reg[l_sect_reg];
				imm_data[SPP_VOL_LD_BIT] = vol_ld_reg[l_sect_reg];
			end
			SPP_CMD_CHECK_PE: imm_ok = access_ok;
			default: imm_ok = 1'b0;
		endcase
	end

	// sequencer: immediate commands answer in the taking cycle, cell writes after the timer
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg <= SPP_IDLE;
			cnt_reg <= 32'h0000_0000;
			ack_tgl_reg <= 1'b0;
			c_ok_reg <= 1'b0;
			c_data_reg <= '0;
		end
		else
		begin
			unique case (state_reg)
				SPP_IDLE:
				begin
					if (exec && spp_is_nv_op(l_cmd_reg) && nv_ok)
					begin
						state_reg <= SPP_BUSY;
						// erase of all lock bits costs a sector erase, the rest a byte program
						cnt_reg <= (l_cmd_reg == SPP_CMD_ERASE_NVL) ? 32'(ERASE_CYCLES - 1) :
							32'(PROG_CYCLES - 1);
					end
					else if (exec)
					begin
						ack_tgl_reg <= ~ack_tgl_reg;
						c_ok_reg <= spp_is_nv_op(l_cmd_reg) ? 1'b0 : imm_ok;
						c_data_reg <= spp_is_nv_op(l_cmd_reg) ? '0 : imm_data;
					end
				end
				SPP_BUSY:
				begin
					if (done)
					begin
						state_reg <= SPP_IDLE;
						ack_tgl_reg <= ~ack_tgl_reg;
						c_ok_reg <= 1'b1;
						c_data_reg <= '0;
					end
					else
					begin
						cnt_reg <= cnt_reg - 32'h0000_0001;
					end
				end
			endcase
		end
	end

	// protection mode register, written only at the end of a programming cycle
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			mode_reg <= SPP_MODE_RESET;
		else if (done && l_cmd_reg == SPP_CMD_WR_MODE)
			mode_reg <= mode_next;
	end

	// password store; frozen for good once password mode is on
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			pw_reg <= '0;
		else if (done && l_cmd_reg == SPP_CMD_WR_PW && !pw_on)
			pw_reg <= l_data_reg;
	end

	// freeze bit; a device reset brings it up locked when password mode is on
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			freeze_reg <= SPP_FREEZE_RESET;
		else if (volatile_reset)
			freeze_reg <= pw_on ? 1'b0 : SPP_FREEZE_RESET;
		else if (exec && l_cmd_reg == SPP_CMD_WR_FREEZE)
			freeze_reg <= 1'b0;
		else if (exec && l_cmd_reg == SPP_CMD_UNLOCK_PW && (!pw_on || pw_match))
			freeze_reg <= 1'b1;
	end

	// nonvolatile sector locks: shipped all unlocked, untouched by device reset
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			nvl_reg <= {SECTORS{1'b1}};
		else if (done && l_cmd_reg == SPP_CMD_WR_NVL)
			nvl_reg[l_sect_reg] <= 1'b0;
		else if (done && l_cmd_reg == SPP_CMD_ERASE_NVL)
			nvl_reg <= {SECTORS{1'b1}};
	end

	// volatile locks and lock-down, cleared by any reset
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			vol_wl_reg <= '0;
			vol_ld_reg <= '0;
		end
		else if (volatile_reset)
		begin
			vol_wl_reg <= '0;
			vol_ld_reg <= '0;
		end
		else if (exec && l_cmd_reg == SPP_CMD_WR_VOL && !vol_ld_reg[l_sect_reg])
		begin
			vol_wl_reg[l_sect_reg] <= l_data_reg[SPP_VOL_WL_BIT];
			vol_ld_reg[l_sect_reg] <= l_data_reg[SPP_VOL_LD_BIT];
		end
	end

	// password mode and sector mode bits are never both cleared
	a_mode_exclusive: assert property (@(posedge core_clk) disable iff (!reset_n)
		mode_reg[SPP_MODE_PW_BIT] || mode_reg[SPP_MODE_SP_BIT])
		else $error("both protection mode bits cleared");
	// a cleared mode bit never returns to 1
	a_mode_otp: assert property (@(posedge core_clk) disable iff (!reset_n)
		!$rose(mode_reg[SPP_MODE_PW_BIT]) && !$rose(mode_reg[SPP_MODE_SP_BIT]))
		else $error("one-time mode bit went back to 1");
	// password unchanged while password mode is on
	a_pw_frozen: assert property (@(posedge core_clk) disable iff (!reset_n)
		pw_on |=> $stable(pw_reg))
		else $error("password changed in password mode");
	// in password mode only a matching unlock may raise the freeze bit
	a_freeze_guard: assert property (@(posedge core_clk) disable iff (!reset_n)
		pw_on && !freeze_reg && !(exec && l_cmd_reg == SPP_CMD_UNLOCK_PW && pw_match)
		|=> !freeze_reg)
		else $error("freeze bit rose without the password");
	// a matching unlock raises the freeze bit one cycle later
	a_unlock_sets: assert property (@(posedge core_clk) disable iff (!reset_n)
		exec && l_cmd_reg == SPP_CMD_UNLOCK_PW && pw_match && !volatile_reset |=> freeze_reg)
		else $error("correct unlock did not set freeze bit");
	// nonvolatile locks hold while frozen
	a_nvl_frozen: assert property (@(posedge core_clk) disable iff (!reset_n)
		!freeze_reg && state_reg == SPP_IDLE |=> $stable(nvl_reg))
		else $error("nonvolatile lock changed while frozen");

	// program/erase check answers per both locks
	a_access_block: assert property (@(posedge core_clk) disable iff (!reset_n)
		exec && l_cmd_reg == SPP_CMD_CHECK_PE |=> c_ok_reg == $past(access_ok))
		else $error("access answer disagrees with sector locks");

	// locked-down sectors keep their volatile bits
	a_vol_lockdown: assert property (@(posedge core_clk) disable iff (!reset_n)
		!volatile_reset |=> ((vol_wl_reg ^ $past(vol_wl_reg)) & $past(vol_ld_reg)) == '0)
		else $error("volatile bit written under lock-down");

	// device reset clears every volatile lock
	a_vol_reset: assert property (@(posedge core_clk) disable iff (!reset_n)
		volatile_reset |=> vol_wl_reg == '0 && vol_ld_reg == '0)
		else $error("volatile locks survived reset");

	// an answer always reopens the command port
	a_link_answer: assert property (@(posedge sclk) disable iff (!reset_n)
		rsp_valid |-> cmd_ready)
		else $error("answer given while port still busy");

	c_unlock_ok: cover property (@(posedge core_clk) disable iff (!reset_n)
		pw_on && !freeze_reg ##1 freeze_reg);
	c_erase_done: cover property (@(posedge core_clk) disable iff (!reset_n)
		done && l_cmd_reg == SPP_CMD_ERASE_NVL);
	c_check_blocked: cover property (@(posedge core_clk) disable iff (!reset_n)
		exec && l_cmd_reg == SPP_CMD_CHECK_PE && !access_ok);

endmodule : spp_sector_protect

`default_nettype wire

/* spp_pkg.sv */
// shared constants, command codes and state encodings for sector password protection
package spp_pkg;

	// sector geometry; the count is a plain default, override per part
	localparam int SPP_SECTORS = 512;
	localparam int SPP_SECT_W = 9;

	// protection mode register: 16 bits, reserved bits read as 1
	localparam logic [15:0] SPP_MODE_RESET = 16'hFFFF;
	localparam int SPP_MODE_W = 16;
	localparam int SPP_MODE_PW_BIT = 2;
	localparam int SPP_MODE_SP_BIT = 1;

	// freeze register: bit 0 live, bits 7:1 read as 0
	localparam int SPP_FREEZE_W = 8;
	localparam logic SPP_FREEZE_RESET = 1'b1;
	localparam logic [6:0] SPP_FREEZE_RSVD = 7'h00;

	// per-sector volatile lock register fields
	localparam int SPP_VOL_WL_BIT = 0;
	localparam int SPP_VOL_LD_BIT = 1;

	// password and response widths
	localparam int SPP_PW_W = 64;
	localparam int SPP_DATA_W = 64;

	// timing: core clock rate and nonvolatile cell times (typical)
	localparam int SPP_CORE_CLK_MHZ = 200;
	localparam int SPP_PROG_TIME_NS = 2000;
	localparam int SPP_ERASE_TIME_NS = 250000;
	localparam int SPP_PROG_CYCLES = (SPP_PROG_TIME_NS * SPP_CORE_CLK_MHZ + 999) / 1000;
	localparam int SPP_ERASE_CYCLES = (SPP_ERASE_TIME_NS * SPP_CORE_CLK_MHZ + 999) / 1000;

	// protection commands as seen after serial framing
	typedef enum logic [3:0] {
		SPP_CMD_RD_MODE = 4'h0,
		SPP_CMD_WR_MODE = 4'h1,
		SPP_CMD_RD_FREEZE = 4'h2,
		SPP_CMD_WR_FREEZE = 4'h3,
		SPP_CMD_UNLOCK_PW = 4'h4,
		SPP_CMD_WR_PW = 4'h5,
		SPP_CMD_RD_PW = 4'h6,
		SPP_CMD_WR_NVL = 4'h7,
		SPP_CMD_ERASE_NVL = 4'h8,
		SPP_CMD_RD_NVL = 4'h9,
		SPP_CMD_WR_VOL = 4'hA,
		SPP_CMD_RD_VOL = 4'hB,
		SPP_CMD_CHECK_PE = 4'hC
	} spp_cmd_e;

	// core sequencer states
	typedef enum logic [1:0] {
		SPP_IDLE = 2'b01,
		SPP_BUSY = 2'b10
	} spp_state_e;

endpackage : spp_pkg

/* spp_host_model.sv */
// host model: issues one protection command at a time on a gated link clock
`timescale 1ns/1ps
`default_nettype none

module spp_host_model
	import spp_pkg::*;
(
	input wire logic sclk_free,
	input wire logic link_on,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic rsp_ok,
	input wire logic [SPP_DATA_W-1:0] rsp_data,
	output logic sclk,
	output logic cmd_valid,
	output var spp_cmd_e cmd_code,
	output logic [SPP_SECT_W-1:0] cmd_sector,
	output logic [SPP_DATA_W-1:0] cmd_data
);
	logic run;

	// link clock stands still between commands, so a design that needs free edges shows up
	assign sclk = sclk_free & (run | link_on);

	initial
	begin
		run = 1'b0;
		cmd_valid = 1'b0;
		cmd_code = SPP_CMD_RD_MODE;
		cmd_sector = '0;
		cmd_data = '0;
	end

	// one whole command, request driven for one link cycle once ready is seen, answer awaited under a bound
	task automatic xfer(input spp_cmd_e code, input logic [SPP_SECT_W-1:0] sec,
		input logic [SPP_DATA_W-1:0] data, output logic ok,
		output logic [SPP_DATA_W-1:0] rd, output logic hung);
		int n;
		hung = 1'b1;
		ok = 1'bx;
		rd = 'x;
		n = 0;
		@(negedge sclk_free);
		run = 1'b1;
		while (cmd_ready !== 1'b1 && n < 50)
		begin
			@(negedge sclk_free);
			n++;
		end
		cmd_valid = 1'b1;
		cmd_code = code;
		cmd_sector = sec;
		cmd_data = data;
		@(negedge sclk_free);
		// released lines carry the inverse, never a stale copy
		cmd_valid = 1'b0;
		cmd_code = spp_cmd_e'(~code);
		cmd_sector = ~sec;
		cmd_data = ~data;
		for (n = 0; n < 300 && hung; n++)
		begin
			@(negedge sclk_free);
			if (rsp_valid === 1'b1)
			begin
				hung = 1'b0;
				ok = rsp_ok;
				rd = rsp_data;
			end
		end
		@(negedge sclk_free);
		run = 1'b0;
	endtask : xfer

endmodule : spp_host_model

`default_nettype wire

/* tb.sv */
// self-checking bench for the sector password protection core
`timescale 1ns/1ps
`default_nettype none

`define CHK(name, exp, got) \
	begin \
		cmp_count++; \
		if ((got) !== (exp)) \
		begin \
			n_errors++; \
			$display("ERROR %s expected %h seen %h", name, exp, got); \
		end \
	end

module tb
	import spp_pkg::*;
;
	localparam logic [63:0] TB_PW = 64'hA5C3_0F1E_7B2D_9468;
	logic core_clk;
	logic sclk_free;
	logic sclk;
	logic reset_n;
	logic volatile_reset;
	logic link_on;
	logic cmd_valid;
	spp_cmd_e cmd_code;
	logic [SPP_SECT_W-1:0] cmd_sector;
	logic [SPP_DATA_W-1:0] cmd_data;
	logic cmd_ready;
	logic rsp_valid;
	logic rsp_ok;
	logic [SPP_DATA_W-1:0] rsp_data;
	int n_errors;
	int cmp_count;

	// short cell times keep the run brief; expectations do not depend on them
	spp_sector_protect #(.PROG_CYCLES(4), .ERASE_CYCLES(8)) spp_sector_protect_i (
		.core_clk(core_clk), .reset_n(reset_n), .volatile_reset(volatile_reset),
		.sclk(sclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_sector(cmd_sector),
		.cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_ok(rsp_ok), .rsp_data(rsp_data));

	spp_host_model spp_host_model_i (
		.sclk_free(sclk_free), .link_on(link_on), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_data(rsp_data), .sclk(sclk),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_sector(cmd_sector),
		.cmd_data(cmd_data));

	// core clock 5 ns, link clock 15 ns with an odd phase offset
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	initial
	begin
		sclk_free = 1'b0;
		#3.1;
		forever #7.5 sclk_free = ~sclk_free;
	end

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	// full power-on; the link clock runs meanwhile so both domains see reset edges
	task automatic power_up();
		@(negedge sclk_free);
		link_on = 1'b1;
		@(negedge core_clk);
		reset_n = 1'b0;
		repeat (16) @(negedge core_clk);
		reset_n = 1'b1;
		@(negedge sclk_free);
		link_on = 1'b0;
	endtask : power_up

	task automatic vol_reset();
		@(negedge core_clk);
		volatile_reset = 1'b1;
		@(negedge core_clk);
		volatile_reset = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask : vol_reset

	task automatic c(input spp_cmd_e code, input int sec, input logic [63:0] data,
		input logic exp_ok, input logic [63:0] exp_rd);
		logic ok;
		logic [63:0] rd;
		logic hung;
		spp_host_model_i.xfer(code, sec[SPP_SECT_W-1:0], data, ok, rd, hung);
		`CHK("answer timeout", 1'b0, hung)
		`CHK(code.name(), exp_ok, ok)
		`CHK("rsp_data", exp_rd, rd)
	endtask : c

	initial
	begin
		n_errors = 0;
		cmp_count = 0;
		// reset from time zero so no assertion ever sees unreset state
		reset_n = 1'b0;
		volatile_reset = 1'b0;
		link_on = 1'b0;
		power_up();
		c(SPP_CMD_RD_MODE, 0, 64'h0, 1'b1, 64'hFFFF);
		c(SPP_CMD_RD_FREEZE, 0, 64'h0, 1'b1, 64'h1);
		c(SPP_CMD_RD_NVL, 511, 64'h0, 1'b1, 64'h1);
		c(SPP_CMD_CHECK_PE, 3, 64'h0, 1'b1, 64'h0);
		c(SPP_CMD_WR_NVL, 5, 64'h0, 1'b1, 64'h0);
		c(SPP_CMD_RD_NVL, 5, 64'h0, 1'b1, 64'h0);
		c(SPP_CMD_RD_NVL, 6, 64'h0, 1'b1, 64'h1);
		c(SPP_CMD_CHECK_PE, 5, 64'h0, 1'b0, 64'h0);
		c(SPP_CMD_WR_VOL, 7, 64'h1, 1'b1, 64'h0);
		c(SPP_CMD_RD_VOL, 7, 64'h0, 1'b1, 64'h1);
		c(SPP_CMD_CHECK_PE, 7, 64'h0, 1'b0, 64'h0);
		c(SPP_CMD_WR_VOL, 8, 64'h3, 1'b1, 64'h0);
		c(SPP_CMD_WR_VOL, 8, 64'h0, 1'b0, 64'h0);
		c(SPP_CMD_RD_VOL, 8, 64'h0, 1'b1, 64'h3);
		vol_reset();
		c(SPP_CMD_RD_VOL, 8, 64'h0, 1'b1, 64'h0);
		c(SPP_CMD_CHECK_PE, 7, 64'h0, 1'b1, 64'h0);
		c(SPP_CMD_RD_NVL, 5, 64'h0, 1'b1, 64'h0);
		// freeze only once the nonvolatile locks are in place
		c(SPP_CMD_WR_FREEZE, 0, 64'h0, 1'b1, 64'h0);
		c(SPP_CMD_RD_FREEZE, 0, 64'h0, 1'b1, 64'h0);
		c(SPP_CMD_WR_NVL, 6, 64'h0, 1'b0, 64'h0);
		c(SPP_CMD_ERASE_NVL, 0, 64'h0, 1'b0, 64'h0);
		c(SPP_CMD_UNLOCK_PW, 0, 64'h0, 1'b1, 64'h0);
		c(SPP_CMD_ERASE_NVL, 0, 64'h0, 1'b1, 64'h0);
		c(SPP_CMD_RD_NVL, 5, 64'h0, 1'b1, 64'h1);
		// password stored and read back before the one mode bit is cleared
		c(SPP_CMD_WR_PW, 0, TB_PW, 1'b1, 64'h0);
		c(SPP_CMD_RD_PW, 0, 64'h0, 1'b1, TB_PW);
		c(SPP_CMD_WR_MODE, 0, 64'hFFFB, 1'b1, 64'h0);
		c(SPP_CMD_RD_MODE, 0, 64'h0, 1'b1, 64'hFFFB);
		c(SPP_CMD_WR_MODE, 0, 64'hFFFD, 1'b0, 64'h0);
		c(SPP_CMD_RD_MODE, 0, 64'h0, 1'b1, 64'hFFFB);
		c(SPP_CMD_WR_PW, 0, ~TB_PW, 1'b0, 64'h0);
		c(SPP_CMD_RD_PW, 0, 64'h0, 1'b0, 64'h0);
		vol_reset();
		c(SPP_CMD_RD_FREEZE, 0, 64'h0, 1'b1, 64'h0);
		c(SPP_CMD_WR_NVL, 2, 64'h0, 1'b0, 64'h0);
		c(SPP_CMD_UNLOCK_PW, 0, TB_PW ^ 64'h8000_0000_0000_0000, 1'b0, 64'h0);
		c(SPP_CMD_UNLOCK_PW, 0, TB_PW ^ 64'h1, 1'b0, 64'h0);
		c(SPP_CMD_RD_FREEZE, 0, 64'h0, 1'b1, 64'h0);
		c(SPP_CMD_UNLOCK_PW, 0, TB_PW, 1'b1, 64'h0);
		c(SPP_CMD_RD_FREEZE, 0, 64'h0, 1'b1, 64'h1);
		c(SPP_CMD_WR_NVL, 2, 64'h0, 1'b1, 64'h0);
		// a fresh part that takes the other mode bit instead
		power_up();
		c(SPP_CMD_RD_NVL, 2, 64'h0, 1'b1, 64'h1);
		c(SPP_CMD_WR_MODE, 0, 64'hFFFD, 1'b1, 64'h0);
		c(SPP_CMD_WR_MODE, 0, 64'hFFFB, 1'b0, 64'h0);
		c(SPP_CMD_RD_MODE, 0, 64'h0, 1'b1, 64'hFFFD);
		c(SPP_CMD_WR_NVL, 9, 64'h0, 1'b1, 64'h0);
		c(SPP_CMD_RD_NVL, 9, 64'h0, 1'b1, 64'h0);
		results();
	end

	// about 50 commands of well under 1 us each; a hang ends here
	initial
	begin
		#200000;
		n_errors++;
		$display("ERROR watchdog expected finish seen hang");
		results();
	end

endmodule : tb

`default_nettype wire
